// File: cad_pkg.sv
/*
 * Shared constants for the processor-side address decoder, bus time-out
 * logic and boot RAM. Assumes one clock with a synchronous active-low reset.
 */
// How it works
// - boot RAM has two independent single-cycle ports
// - load-use hazard stalls front pipeline one cycle
// - boot RAM size configurable 1KB to 16MB
// - 0000_0000h-00FF_FFFFh decodes to boot RAM
// - 0100_0000h-7FFF_FFFFh goes to external memory
// - external strobe starts 4096-cycle acknowledge time-out
// - core abandons unwaited access after 16 cycles
// - 8000_0000h-FEFF_FFFFh reserved, reaches no resource
// - peripheral port FF00_0000h up, 24-bit address
// - peripheral port has own 4096-cycle time-out
// - multi-byte operands little-endian in byte lanes
package cad_pkg;
   localparam logic [31:0] RAM_LO  = 32'h0000_0000;
   localparam logic [31:0] RAM_HI  = 32'h00FF_FFFF;
   localparam logic [31:0] EXT_LO  = 32'h0100_0000;
   localparam logic [31:0] EXT_HI  = 32'h7FFF_FFFF;
   localparam logic [31:0] RESV_LO = 32'h0800_0000;
   localparam logic [31:0] RESV_HI = 32'hFEFF_FFFF;
   localparam logic [31:0] IO_LO   = 32'hFF00_0000;

   localparam int IO_AW            = 24;
   localparam int KB               = 1024;
   localparam int RAM_MIN_BYTES    = KB;
   localparam int RAM_MAX_BYTES    = 16 * KB * KB;
   localparam int RAM_DEF_BYTES    = 16 * KB;
   localparam int ACK_TIMEOUT_CYC  = 4096;
   localparam int CORE_ABANDON_CYC = 16;
   localparam int PORTS            = 2;
   localparam int P_EXT            = 0;
   localparam int P_IO             = 1;

   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_BUSY  = 3'b001,
      ST_DONE  = 3'b011,
      ST_FAULT = 3'b010,
      ST_RAMRD = 3'b100
   } cad_state_t;

   typedef enum logic [1:0] {
      RG_RAM  = 2'h0,
      RG_EXT  = 2'h1,
      RG_IO   = 2'h2,
      RG_RESV = 2'h3
   } cad_region_t;
endpackage

// File: cad_ram_if.sv
/*
 * One port of the boot RAM: enable, write, byte lanes, data both ways.
 * Assumes the requester holds its signals for the cycle it enables.
 */
`timescale 1ns/10ps
interface cad_ram_if #(parameter int AW = 12);
   logic          en;
   logic          we;
   logic [AW-1:0] addr;
   logic [3:0]    sel;
   logic [31:0]   wdata;
   logic [31:0]   rdata;
   modport requester (output en, we, addr, sel, wdata, input rdata);
   modport memory    (input en, we, addr, sel, wdata, output rdata);
endinterface

// File: cad_boot_ram.sv
/*
 * True dual-port boot RAM with byte-lane writes, read data one cycle after
 * enable on each port. Assumes both ports are driven on sys_clk.
 */
`timescale 1ns/10ps
module cad_boot_ram
   import cad_pkg::*;
#(
   parameter int AW = 12
) (
   input wire logic   sys_clk, // system clock
   cad_ram_if.memory  portA,   // instruction-side port
   cad_ram_if.memory  portB    // data-side port
);
   localparam int DEPTH = 1 << AW;

   logic [31:0] mem [DEPTH];
   logic [31:0] rdA;
   logic [31:0] rdB;

   // both ports serve a read or write in the same cycle; B wins a write clash
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (portA.en && portA.we && portA.sel[i] &&
             !(portB.en && portB.we && portB.sel[i] && portB.addr == portA.addr)) begin
            mem[portA.addr][i*8 +: 8] <= portA.wdata[i*8 +: 8];
         end
         if (portB.en && portB.we && portB.sel[i]) begin
            mem[portB.addr][i*8 +: 8] <= portB.wdata[i*8 +: 8];
         end
      end
      if (portA.en) begin
         rdA <= mem[portA.addr];
      end
      if (portB.en) begin
         rdB <= mem[portB.addr];
      end
   end

   assign portA.rdata = rdA;
   assign portB.rdata = rdB;
endmodule // cad_boot_ram

// File: cad_addr_decode.sv
/*
 * Address-space decoder and bus time-out wrapper between the processor core
 * and its boot RAM, external memory port and peripheral port.
 * Assumes the core holds a request until it sees coreAck or coreErr.
 */
`timescale 1ns/10ps
module cad_addr_decode
   import cad_pkg::*;
#(
   parameter int RAM_BYTES   = RAM_DEF_BYTES,   // boot RAM size in bytes
   parameter int ACK_TIMEOUT = ACK_TIMEOUT_CYC, // acknowledge time-out
   parameter int ABANDON     = CORE_ABANDON_CYC // core give-up count
) (
   input  wire logic              sys_clk,        // system clock
   input  wire logic              rst_n,          // sync reset, active low
   // core data request
   input  wire logic              coreCyc,        // bus cycle active
   input  wire logic              coreStb,        // request strobe
   input  wire logic              coreWe,         // write
   input  wire logic [1:0]        coreSize,       // byte, half or word
   input  wire logic              coreSigned,     // sign-extend read
   input  wire logic [31:0]       coreAddr,       // byte address
   input  wire logic [31:0]       coreWdata,      // LSB-aligned write data
   output logic                   coreAck,        // transfer done
   output logic                   coreErr,        // transfer abandoned
   output logic                   coreWait,       // wait request
   output logic [31:0]            coreRdata,      // LSB-aligned read data
   // core instruction fetch from boot RAM
   input  wire logic              fetchEn,        // fetch enable
   input  wire logic [31:0]       fetchAddr,      // fetch byte address
   output logic [31:0]            fetchData,      // fetched word
   // load-use hazard
   input  wire logic              exLoad,         // execute stage is a load
   input  wire logic [4:0]        exDest,         // load destination
   input  wire logic [4:0]        idSrcA,         // decode source A
   input  wire logic [4:0]        idSrcB,         // decode source B
   output logic                   loadStall,      // hold front half
   // external memory port
   output logic                   extmemCycOut,   // cycle
   output logic                   extmemStrobeOut,// strobe
   output logic [31:0]            extmemAddrOut,  // byte address
   input  wire logic              extmemAckIn,    // acknowledge
   input  wire logic [31:0]       extmemDataIn,   // read data
   // peripheral port
   output logic                   periphCycOut,   // cycle
   output logic                   periphStrobeOut,// strobe
   output logic [IO_AW-1:0]       periphAddrOut,  // physical address
   input  wire logic              periphAckIn,    // acknowledge
   input  wire logic [31:0]       periphDataIn,   // read data
   // shared write side of both ports
   output logic                   busWeOut,       // write enable
   output logic [3:0]             busSelOut,      // byte lanes
   output logic [31:0]            busDataOut      // write data
);
   // size clamped to the supported range
   localparam int RAM_EFF = (RAM_BYTES < RAM_MIN_BYTES) ? RAM_MIN_BYTES :
                            (RAM_BYTES > RAM_MAX_BYTES) ? RAM_MAX_BYTES : RAM_BYTES;
   localparam int RAM_AW  = $clog2(RAM_EFF / 4);
   localparam int TW      = $clog2(ACK_TIMEOUT + 1);
   localparam int CW      = $clog2(ABANDON + 1);
   localparam logic [TW-1:0] TO_LAST = TW'(ACK_TIMEOUT - 1);
   localparam logic [CW-1:0] AB_LAST = CW'(ABANDON - 1);

   // little-endian lane enables for an access of the given size
   function automatic logic [3:0] laneSel(input logic [1:0] sz, input logic [1:0] off);
      logic [3:0] base;
      base = (sz == SZ_BYTE) ? 4'h1 : (sz == SZ_HALF) ? 4'h3 : 4'hF;
      return 4'(base << off);
   endfunction

   // lowest byte of the operand sits at the lowest address
   function automatic logic [31:0] readAlign(input logic [31:0] w, input logic [1:0] off,
                                             input logic [1:0] sz, input logic sgn);
      logic [31:0] s;
      s = w >> {off, 3'h0};
      if (sz == SZ_BYTE) begin
         return {{24{sgn & s[7]}}, s[7:0]};
      end else if (sz == SZ_HALF) begin
         return {{16{sgn & s[15]}}, s[15:0]};
      end
      return s;
   endfunction

   // region decode
   wire inRam  = coreAddr <= RAM_HI;
   wire inIo   = coreAddr >= IO_LO;
   wire inExt  = coreAddr >= EXT_LO && coreAddr <= EXT_HI;
   // external range wins where it overlaps the reserved one
   wire inResv = coreAddr >= RESV_LO && coreAddr <= RESV_HI && !inExt;
   cad_region_t region;
   assign region = inRam ? RG_RAM : inIo ? RG_IO : inResv ? RG_RESV : RG_EXT;

   wire [1:0]  off     = coreAddr[1:0];
   wire [3:0]  sel     = laneSel(coreSize, off);
   wire [31:0] wdLanes = coreWdata << {off, 3'h0};
   wire        request = coreCyc && coreStb;

   cad_state_t state;
   cad_state_t next_state;
   logic [TW-1:0] ackCnt [PORTS];
   logic [CW-1:0] abandonCnt;
   logic [PORTS-1:0] portStb;
   logic [PORTS-1:0] portAck;
   logic [PORTS-1:0] portExpire;
   logic [31:0] portData;
   logic [1:0]  heldOff;
   logic [1:0]  heldSize;
   logic        heldSigned;

   assign portStb = {periphStrobeOut, extmemStrobeOut};
   assign portAck = {periphAckIn, extmemAckIn};
   assign portData = periphStrobeOut ? periphDataIn : extmemDataIn;

   // each port keeps its own acknowledge timer
   for (genvar p = 0; p < PORTS; p++) begin : g_timer
      // an ack in the last counted cycle still beats the expiry
      assign portExpire[p] = portStb[p] && !portAck[p] && ackCnt[p] == TO_LAST;
      always_ff @(posedge sys_clk) begin
         if (!rst_n || !portStb[p] || portAck[p]) begin
            ackCnt[p] <= '0;
         end else begin
            ackCnt[p] <= ackCnt[p] + TW'(1);
         end
      end
   end

   wire anyAck    = |(portStb & portAck);
   wire anyExpire = |portExpire;
   wire abandonNow = state == ST_FAULT && abandonCnt == AB_LAST;

   // boot RAM ports
   cad_ram_if #(.AW(RAM_AW)) ramA ();
   cad_ram_if #(.AW(RAM_AW)) ramB ();

   assign ramA.en    = fetchEn;
   assign ramA.we    = 1'b0;
   assign ramA.addr  = fetchAddr[RAM_AW+1:2];
   assign ramA.sel   = 4'hF;
   assign ramA.wdata = '0;
   assign fetchData  = ramA.rdata;

   wire ramStart = state == ST_IDLE && request && region == RG_RAM;
   assign ramB.en    = ramStart;
   assign ramB.we    = coreWe;
   assign ramB.addr  = coreAddr[RAM_AW+1:2];
   assign ramB.sel   = sel;
   assign ramB.wdata = wdLanes;

   cad_boot_ram #(.AW(RAM_AW)) u_ram (
      .sys_clk (sys_clk),
      .portA   (ramA),
      .portB   (ramB)
   );

   // transfer sequencing
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (request) begin
               if (region == RG_RAM) begin
                  next_state = ST_RAMRD;
               end else if (region == RG_RESV) begin
                  next_state = ST_FAULT;
               end else begin
                  next_state = ST_BUSY;
               end
            end
         end
         ST_RAMRD: begin
            next_state = ST_DONE;
         end
         ST_BUSY: begin
            if (!request) begin
               next_state = ST_IDLE;
            end else if (anyAck) begin
               next_state = ST_DONE;
            end else if (anyExpire) begin
               next_state = ST_FAULT;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         ST_FAULT: begin
            if (abandonNow) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // core gives up after a fixed count once nobody asks it to wait
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state != ST_FAULT) begin
         abandonCnt <= '0;
      end else begin
         abandonCnt <= abandonCnt + CW'(1);
      end
   end

   wire toExt = region == RG_EXT;
   wire toIo  = region == RG_IO;
   wire issue = state == ST_IDLE && request && (toExt || toIo);
   wire drop  = state == ST_BUSY && (!request || anyAck || anyExpire);
   wire take  = issue || ramStart;

   // a strobe falls at ack, at expiry or when the core withdraws its request
   always_ff @(posedge sys_clk) begin
      if (!rst_n || drop) begin
         extmemCycOut    <= 1'b0;
         extmemStrobeOut <= 1'b0;
      end else if (issue) begin
         extmemCycOut    <= toExt;
         extmemStrobeOut <= toExt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || drop) begin
         periphCycOut    <= 1'b0;
         periphStrobeOut <= 1'b0;
      end else if (issue) begin
         periphCycOut    <= toIo;
         periphStrobeOut <= toIo;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         extmemAddrOut <= '0;
      end else if (issue && toExt) begin
         extmemAddrOut <= coreAddr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         periphAddrOut <= '0;
      end else if (issue && toIo) begin
         periphAddrOut <= coreAddr[IO_AW-1:0];
      end
   end

   // write side and read alignment are latched for every accepted access
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busWeOut   <= 1'b0;
         busSelOut  <= '0;
         busDataOut <= '0;
      end else if (take) begin
         busWeOut   <= coreWe;
         busSelOut  <= sel;
         busDataOut <= wdLanes;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         heldOff    <= '0;
         heldSize   <= SZ_WORD;
         heldSigned <= 1'b0;
      end else if (take) begin
         heldOff    <= off;
         heldSize   <= coreSize;
         heldSigned <= coreSigned;
      end
   end

   // writes leave the last read data in place
   wire capRam  = state == ST_RAMRD && !busWeOut;
   wire capPort = state == ST_BUSY && anyAck && !busWeOut;

   // read data captured from whichever source finished
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         coreRdata <= '0;
      end else if (capRam) begin
         coreRdata <= readAlign(ramB.rdata, heldOff, heldSize, heldSigned);
      end else if (capPort) begin
         coreRdata <= readAlign(portData, heldOff, heldSize, heldSigned);
      end
   end

   // core-side ack and wait decoded straight from the sequencer state, error from ST_FAULT plus the abandon count
   assign coreAck  = state == ST_DONE;
   assign coreErr  = abandonNow;
   assign coreWait = state == ST_BUSY;

   // hold the front half while the loaded value is not yet there
   assign loadStall = exLoad && (exDest == idSrcA || exDest == idSrcB);
endmodule // cad_addr_decode

// File: cad_addr_decode_chk.sv
/* concurrent checks on the decoder ports: regions, time-outs, lanes
   assumes it is bound to every cad_addr_decode instance */
`timescale 1ns/10ps
module cad_addr_decode_chk
   import cad_pkg::*;
#(
   parameter int ACK_TIMEOUT = ACK_TIMEOUT_CYC // ack time-out
) (
   input wire logic              sys_clk,         // clock
   input wire logic              rst_n,           // reset
   input wire logic              coreCyc,         // cycle
   input wire logic              coreStb,         // strobe
   input wire logic [1:0]        coreSize,        // size
   input wire logic [31:0]       coreAddr,        // address
   input wire logic [31:0]       coreWdata,       // write data
   input wire logic              coreAck,         // done
   input wire logic              coreErr,         // abandoned
   input wire logic              coreWait,        // wait
   input wire logic              extmemStrobeOut, // ext strobe
   input wire logic [31:0]       extmemAddrOut,   // ext address
   input wire logic              extmemAckIn,     // ext ack
   input wire logic              periphStrobeOut, // io strobe
   input wire logic [IO_AW-1:0]  periphAddrOut,   // io address
   input wire logic              periphAckIn,     // io ack
   input wire logic              busWeOut,        // write
   input wire logic [3:0]        busSelOut,       // lanes
   input wire logic [31:0]       busDataOut       // write data
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   int extCnt;
   int ioCnt;
   wire logic req = coreCyc && coreStb;
   // cycles of strobe high with no acknowledge
   always_ff @(posedge sys_clk) begin
      extCnt <= (!rst_n || !extmemStrobeOut || extmemAckIn) ? 0 : extCnt + 1;
      ioCnt  <= (!rst_n || !periphStrobeOut || periphAckIn) ? 0 : ioCnt + 1;
   end
   chk_resv_no_port: assert property (
      req && coreAddr >= 32'h8000_0000 && coreAddr <= RESV_HI
      |=> !extmemStrobeOut && !periphStrobeOut && !coreWait)
      else $error("reserved reached a port");
   chk_ram_no_port: assert property (req && coreAddr <= RAM_HI
      |=> !extmemStrobeOut && !periphStrobeOut) else $error("boot ram access left the core");
   chk_ext_decode: assert property ($rose(extmemStrobeOut) |-> coreAddr >= EXT_LO
      && coreAddr <= EXT_HI && extmemAddrOut == coreAddr) else $error("bad ext decode");
   chk_io_decode: assert property ($rose(periphStrobeOut) |-> coreAddr >= IO_LO
      && periphAddrOut == coreAddr[IO_AW-1:0]) else $error("bad io decode");
   chk_wait_while_strobe: assert property (
      extmemStrobeOut || periphStrobeOut |-> coreWait) else $error("strobe without wait");
   chk_ext_holds: assert property (req && extmemStrobeOut && !extmemAckIn
      && extCnt < ACK_TIMEOUT - 1 |=> extmemStrobeOut) else $error("ext ended early");
   chk_ext_expiry: assert property (extCnt == ACK_TIMEOUT
      |-> !extmemStrobeOut && !coreWait ##[1:40] coreErr) else $error("ext time-out wrong");
   chk_io_expiry: assert property (ioCnt == ACK_TIMEOUT
      |-> !periphStrobeOut && !coreWait ##[1:40] coreErr) else $error("io time-out wrong");
   chk_ack_ends: assert property (extmemStrobeOut && extmemAckIn
      |=> coreAck && !extmemStrobeOut && !coreWait) else $error("ack not passed on");
   chk_byte_lane: assert property ($rose(extmemStrobeOut) && busWeOut
      && coreSize == SZ_BYTE |-> busSelOut == (4'h1 << coreAddr[1:0])
      && busDataOut[8*coreAddr[1:0] +: 8] == coreWdata[7:0]) else $error("bad lane");
   chk_cancel_drops: assert property (coreWait && !req
      |=> !extmemStrobeOut && !periphStrobeOut && !coreAck) else $error("cancel not honoured");
endmodule // cad_addr_decode_chk

bind cad_addr_decode cad_addr_decode_chk #(.ACK_TIMEOUT(ACK_TIMEOUT)) cad_addr_decode_chk_i (
   .sys_clk, .rst_n, .coreCyc, .coreStb, .coreSize, .coreAddr, .coreWdata, .coreAck,
   .coreErr, .coreWait, .extmemStrobeOut, .extmemAddrOut, .extmemAckIn, .periphStrobeOut,
   .periphAddrOut, .periphAckIn, .busWeOut, .busSelOut, .busDataOut);

// File: cad_slave_model.sv
/* far-side slave: acknowledges a strobed cycle after ackDelay cycles,
   never while noAck; assumes master signals change on the rising edge */
`timescale 1ns/10ps
module cad_slave_model #(
   parameter int          AW   = 32,           // address width
   parameter logic [31:0] BASE = 32'hC3A5_0000 // read pattern
) (
   input  wire logic          sys_clk,  // clock
   input  wire logic          cyc,      // cycle
   input  wire logic          stb,      // strobe
   input  wire logic [AW-1:0] addr,     // address
   input  wire logic [7:0]    ackDelay, // wait cycles
   input  wire logic          noAck,    // never answer
   output logic               ack,      // acknowledge
   output logic [31:0]        data      // read data
);
   int cnt = 0;
   initial ack = 1'b0;
   initial data = 32'h0;
   always @(negedge sys_clk) begin
      if (cyc && stb && !ack && !noAck && cnt >= ackDelay) begin
         ack <= 1'b1;
         data <= BASE ^ 32'(addr[15:0]);
      end else begin
         ack <= 1'b0;
         cnt <= (cyc && stb && !ack) ? cnt + 1 : 0;
         // released data lines never keep the last value
         data <= ~data;
      end
   end
endmodule // cad_slave_model

// File: testbench.sv
/* self-checking bench for cad_addr_decode with slave models on both ports
   assumes short time-out and abandon counts set by parameter */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errorCnt++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
   import cad_pkg::*;
   localparam int TMO = 8;
   localparam int ABN = 4;
   localparam logic [31:0] BE = 32'hC3A5_0000;
   localparam logic [31:0] BP = 32'h1E5A_0000;
   logic        sys_clk = 1'b0, rst_n = 1'b0, coreCyc = 1'b0, coreStb = 1'b0, coreWe = 1'b0;
   logic        coreSigned = 1'b0, fetchEn = 1'b0, exLoad = 1'b0, eNo = 1'b0, pNo = 1'b0;
   logic [1:0]  coreSize = SZ_WORD;
   logic [31:0] coreAddr = 32'h0, coreWdata = 32'h0, fetchAddr = 32'h0, rd;
   logic [4:0]  exDest = 5'h0, idSrcA = 5'h0, idSrcB = 5'h0;
   logic [7:0]  eDly = 8'h3, pDly = 8'h0;
   logic        coreAck, coreErr, coreWait, loadStall, eCyc, eStb, eAck, pCyc, pStb, pAck;
   logic        busWe, gotErr;
   logic [31:0] coreRdata, fetchData, eAddr, eData, pData, busData;
   logic [23:0] pAddr;
   logic [3:0]  busSel;
   int          errorCnt = 0, testsRun = 0, cycles = 0, n;
   cad_addr_decode #(.RAM_BYTES(KB), .ACK_TIMEOUT(TMO), .ABANDON(ABN)) cad_addr_decode_i (
      .sys_clk, .rst_n, .coreCyc, .coreStb, .coreWe, .coreSize, .coreSigned, .coreAddr,
      .coreWdata, .coreAck, .coreErr, .coreWait, .coreRdata, .fetchEn, .fetchAddr,
      .fetchData, .exLoad, .exDest, .idSrcA, .idSrcB, .loadStall, .extmemCycOut(eCyc),
      .extmemStrobeOut(eStb), .extmemAddrOut(eAddr), .extmemAckIn(eAck),
      .extmemDataIn(eData), .periphCycOut(pCyc), .periphStrobeOut(pStb),
      .periphAddrOut(pAddr), .periphAckIn(pAck), .periphDataIn(pData), .busWeOut(busWe),
      .busSelOut(busSel), .busDataOut(busData));
   cad_slave_model #(.AW(32), .BASE(BE)) cad_slave_model_i (.sys_clk, .cyc(eCyc),
      .stb(eStb), .addr(eAddr), .ackDelay(eDly), .noAck(eNo), .ack(eAck), .data(eData));
   cad_slave_model #(.AW(24), .BASE(BP)) cad_slave_model_io_i (.sys_clk, .cyc(pCyc),
      .stb(pStb), .addr(pAddr), .ackDelay(pDly), .noAck(pNo), .ack(pAck), .data(pData));
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errorCnt++;
         stopTest();
      end
   end
   task automatic stopTest();
      $display("checks %0d mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one core transfer; n counts cycles until done or abandoned
   task automatic req(input logic [31:0] a, input logic w, input logic [1:0] sz,
                      input logic sg, input logic [31:0] wd);
      @(negedge sys_clk);
      {coreCyc, coreStb, coreWe, coreSize, coreSigned, coreAddr, coreWdata} = {2'b11, w, sz, sg, a, wd};
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (coreAck !== 1'b1 && coreErr !== 1'b1 && n < 100);
      rd = coreRdata;
      gotErr = coreErr;
      @(negedge sys_clk);
      {coreCyc, coreStb} = 2'b00;
   endtask
   task automatic testRam();
      req(32'h100, 1'b1, SZ_WORD, 1'b0, 32'h8877_6655);
      req(32'h102, 1'b1, SZ_BYTE, 1'b0, 32'h99);
      req(32'h100, 1'b0, SZ_WORD, 1'b0, 32'h0);
      `CHK("ram word", 32'h8899_6655, rd)
      `CHK("ram cycles", 2, n)
      req(32'h502, 1'b0, SZ_BYTE, 1'b1, 32'h0);
      `CHK("ram alias byte", 32'hFFFF_FF99, rd)
      // fetch and data read hit the RAM in the same cycle
      @(negedge sys_clk);
      {fetchEn, fetchAddr} = {1'b1, 32'h100};
      {coreCyc, coreStb, coreWe, coreSize, coreAddr} = {2'b11, 1'b0, SZ_WORD, 32'h100};
      @(negedge sys_clk);
      fetchEn = 1'b0;
      `CHK("fetch", 32'h8899_6655, fetchData)
      @(negedge sys_clk);
      `CHK("both ports ack", 1'b1, coreAck)
      `CHK("both ports data", 32'h8899_6655, coreRdata)
      @(negedge sys_clk);
      {coreCyc, coreStb} = 2'b00;
      $display("testRam done");
   endtask
   task automatic testPorts();
      req(EXT_LO, 1'b0, SZ_WORD, 1'b0, 32'h0);
      `CHK("ext low", BE, rd)
      req(32'h7FFF_FFFC, 1'b0, SZ_WORD, 1'b0, 32'h0);
      `CHK("ext high", BE ^ 32'hFFFC, rd)
      req(32'h0100_0002, 1'b0, SZ_HALF, 1'b1, 32'h0);
      `CHK("ext half", 32'hFFFF_C3A5, rd)
      req(32'h0100_0003, 1'b1, SZ_BYTE, 1'b0, 32'h5A);
      `CHK("ext write", 1'b0, gotErr)
      req(32'hFF12_3458, 1'b0, SZ_WORD, 1'b0, 32'h0);
      `CHK("io read", BP ^ 32'h3458, rd)
      $display("testPorts done");
   endtask
   task automatic testFaults();
      req(32'h8000_0000, 1'b0, SZ_WORD, 1'b0, 32'h0);
      `CHK("resv low", 1'b1, gotErr)
      req(RESV_HI - 32'h3, 1'b0, SZ_WORD, 1'b0, 32'h0);
      `CHK("resv cycles", ABN, n)
      eNo = 1'b1;
      req(32'h0200_0000, 1'b0, SZ_WORD, 1'b0, 32'h0);
      eNo = 1'b0;
      `CHK("ext expiry", TMO + ABN, n)
      pNo = 1'b1;
      req(IO_LO, 1'b0, SZ_WORD, 1'b0, 32'h0);
      pNo = 1'b0;
      `CHK("io expiry", 1'b1, gotErr)
      // core withdraws a waiting request: strobe falls, no ack, no error
      eNo = 1'b1;
      @(negedge sys_clk);
      {coreCyc, coreStb, coreWe, coreAddr} = {2'b11, 1'b0, 32'h0400_0000};
      repeat (3) @(negedge sys_clk);
      `CHK("cancel wait", 1'b1, coreWait)
      {coreCyc, coreStb} = 2'b00;
      @(negedge sys_clk);
      `CHK("cancel strobe", 1'b0, eStb)
      `CHK("cancel quiet", 1'b0, coreAck | coreErr | coreWait)
      eNo = 1'b0;
      eDly = 8'(TMO - 3);
      repeat (2) begin
         req(32'h0300_0010, 1'b0, SZ_WORD, 1'b0, 32'h0);
         `CHK("fresh count", 1'b0, gotErr)
      end
      $display("testFaults done");
   endtask
   task automatic testStall();
      logic [15:0] tbl [4] = '{16'h1AA5, 16'h1A5A, 16'h1A67, 16'h0AAA};
      foreach (tbl[i]) begin
         @(negedge sys_clk);
         {exLoad, exDest, idSrcA, idSrcB} = {tbl[i][12], tbl[i][11:8], 1'b0,
                                              tbl[i][7:4], 1'b0, tbl[i][3:0], 1'b0};
         #1 `CHK("stall", (i < 2) ? 1'b1 : 1'b0, loadStall)
      end
      $display("testStall done");
   endtask
   initial begin
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      testRam();
      testPorts();
      testFaults();
      testStall();
      stopTest();
   end
endmodule // testbench
